// ---- rtl/prox_cfg_pkg.sv ----
/*
 constants and carrier types for the proximity/ambient measurement configuration block.
 assumes a single 20 MHz clock domain and a 32-bit avalon-mm register bus.
*/
package prox_cfg_pkg;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          ADDR_W          = 4;
    // printed offsets are not multiples of four: byte address is index times four
    localparam logic [7:0]  IDX_LED3        = 8'h03;
    localparam logic [7:0]  IDX_PROX_ALIGN  = 8'h05;
    localparam logic [7:0]  IDX_AMB_ALIGN   = 8'h06;
    localparam logic [7:0]  IDX_INSEL1      = 8'h07;
    localparam logic [7:0]  IDX_CTRL        = 8'h0C;
    localparam logic [7:0]  IDX_RESULT      = 8'h0D;
    localparam logic [7:0]  IDX_STATUS      = 8'h0E;
    localparam logic [7:0]  RST_LED3        = 8'h04;
    localparam logic [7:0]  RST_PROX_ALIGN  = 8'h00;
    localparam logic [7:0]  RST_AMB_ALIGN   = 8'h00;
    localparam logic [7:0]  RST_INSEL1      = 8'h03;
    localparam logic [7:0]  RST_CTRL        = 8'h01;
    localparam logic [7:0]  MASK_LED3       = 8'h07;
    localparam logic [7:0]  MASK_PROX_ALIGN = 8'h70;
    localparam logic [7:0]  MASK_AMB_ALIGN  = 8'h30;
    localparam int          BIT_ALIGN_P3    = 6;
    localparam int          BIT_ALIGN_P2    = 5;
    localparam int          BIT_ALIGN_P1    = 4;
    localparam int          BIT_ALIGN_VIS   = 5;
    localparam int          BIT_ALIGN_IR    = 4;
    localparam int          BIT_CTRL_MODE   = 0;
    localparam logic [7:0]  MUX_SMALL_IR    = 8'h00;
    localparam logic [7:0]  MUX_VISIBLE     = 8'h02;
    localparam logic [7:0]  MUX_LARGE_IR    = 8'h03;
    localparam logic [7:0]  MUX_NO_PD       = 8'h06;
    localparam logic [7:0]  MUX_GROUND      = 8'h25;
    localparam logic [7:0]  MUX_TEMP        = 8'h65;
    localparam logic [7:0]  MUX_SUPPLY      = 8'h75;

    typedef enum logic [2:0] {
        CH_PROX1 = 3'h0,
        CH_PROX2 = 3'h1,
        CH_PROX3 = 3'h2,
        CH_VIS   = 3'h3,
        CH_IR    = 3'h4
    } channel_t;

    typedef struct packed {
        logic       valid;
        channel_t   channel;
        logic [16:0] raw;
    } conversion_t;

    typedef struct packed {
        logic       valid;
        channel_t   channel;
        logic [15:0] value;
    } report_t;
endpackage

// ---- rtl/prox_ambient_measure_config.sv ----
/*
 configuration registers and result alignment for the proximity and ambient
 measurement sequencer: led selection for the third proximity slot, 16-bit
 alignment of 17-bit conversions, and adc input selection for the first slot.
 assumes the sequencer and adc run on sys_clk_in and present one conversion
 per valid pulse; registers are reached over avalon-mm with waitrequest.
*/
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module prox_ambient_measure_config
(
    input  wire logic                         sys_clk_in,
    input  wire logic                         reset_n_in,
    input  wire logic [prox_cfg_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [31:0]                  avs_writedata_in,
    input  wire logic [3:0]                   avs_byteenable_in,
    output logic [31:0]                       avs_readdata_out,
    output logic                              avs_waitrequest_out,
    input  wire logic                         slot_active_in,
    input  wire prox_cfg_pkg::channel_t       slot_channel_in,
    input  wire prox_cfg_pkg::conversion_t    conv_in,
    output logic [2:0]                        led_drive_out,
    output logic [7:0]                        adc_input_out,
    output prox_cfg_pkg::report_t             report_out
);
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;

    bus_state_t                   bus_q;
    bus_state_t                   bus_d;
    logic                         wait_q;
    logic [7:0]                   led3_q;
    logic [7:0]                   prox_align_q;
    logic [7:0]                   amb_align_q;
    logic [7:0]                   insel1_q;
    logic [7:0]                   ctrl_q;
    logic [7:0]                   insel_bad_q;
    logic [31:0]                  readdata_q;
    logic [2:0]                   led_q;
    logic [7:0]                   adc_in_q;
    prox_cfg_pkg::report_t        report_q;

    wire [7:0] idx          = {{(8 - prox_cfg_pkg::ADDR_W){1'b0}}, avs_address_in};
    wire       hit_led3     = idx == prox_cfg_pkg::IDX_LED3;
    wire       hit_palign   = idx == prox_cfg_pkg::IDX_PROX_ALIGN;
    wire       hit_aalign   = idx == prox_cfg_pkg::IDX_AMB_ALIGN;
    wire       hit_insel1   = idx == prox_cfg_pkg::IDX_INSEL1;
    wire       hit_ctrl     = idx == prox_cfg_pkg::IDX_CTRL;
    wire       hit_result   = idx == prox_cfg_pkg::IDX_RESULT;
    wire       hit_status   = idx == prox_cfg_pkg::IDX_STATUS;
    // a write lands on the edge where the master sees waitrequest low
    wire       wr_take      = avs_write_in && bus_q == BUS_ACK && avs_byteenable_in[0];
    wire [7:0] wbyte        = avs_writedata_in[7:0];
    wire       raw_mode     = !ctrl_q[prox_cfg_pkg::BIT_CTRL_MODE];

    // legal input codes per mode; a bad code is flagged, not blocked
    wire code_normal = insel1_q == prox_cfg_pkg::MUX_LARGE_IR ||
                       insel1_q == prox_cfg_pkg::MUX_SMALL_IR;
    wire code_raw    = code_normal ||
                       insel1_q == prox_cfg_pkg::MUX_VISIBLE ||
                       insel1_q == prox_cfg_pkg::MUX_NO_PD ||
                       insel1_q == prox_cfg_pkg::MUX_GROUND ||
                       insel1_q == prox_cfg_pkg::MUX_TEMP ||
                       insel1_q == prox_cfg_pkg::MUX_SUPPLY;
    wire code_ok     = raw_mode ? code_raw : code_normal;

    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit_led3)
        begin
            rd_word[7:0] = led3_q;
        end
        else if (hit_palign)
        begin
            rd_word[7:0] = prox_align_q;
        end
        else if (hit_aalign)
        begin
            rd_word[7:0] = amb_align_q;
        end
        else if (hit_insel1)
        begin
            rd_word[7:0] = insel1_q;
        end
        else if (hit_ctrl)
        begin
            rd_word[7:0] = ctrl_q;
        end
        else if (hit_result)
        begin
            rd_word[15:0] = report_q.value;
        end
        else if (hit_status)
        begin
            rd_word[7:0] = insel_bad_q;
        end
    end

    // per-channel alignment choice
    logic align_low;
    always_comb
    begin
        case (conv_in.channel)
            prox_cfg_pkg::CH_PROX1: align_low = prox_align_q[prox_cfg_pkg::BIT_ALIGN_P1];
            prox_cfg_pkg::CH_PROX2: align_low = prox_align_q[prox_cfg_pkg::BIT_ALIGN_P2];
            prox_cfg_pkg::CH_PROX3: align_low = prox_align_q[prox_cfg_pkg::BIT_ALIGN_P3];
            prox_cfg_pkg::CH_VIS:   align_low = amb_align_q[prox_cfg_pkg::BIT_ALIGN_VIS];
            prox_cfg_pkg::CH_IR:    align_low = amb_align_q[prox_cfg_pkg::BIT_ALIGN_IR];
            default:                align_low = 1'b0;
        endcase
    end

    wire [15:0] aligned = align_low ? conv_in.raw[15:0] : conv_in.raw[16:1];

    // led drive only in the third slot and never in raw mode
    wire [2:0] led_next = (slot_active_in && slot_channel_in == prox_cfg_pkg::CH_PROX3
                           && !raw_mode) ? led3_q[2:0] : 3'b000;

    // one wait cycle then the ack; done state forces release before the next request
    always_comb
    begin
        case (bus_q)
            BUS_IDLE: bus_d = (avs_read_in || avs_write_in) ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  bus_d = BUS_DONE;
            BUS_DONE: bus_d = BUS_IDLE;
            default:  bus_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            bus_q <= BUS_IDLE;
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    // waitrequest is registered from the next state so the port leaves a flip-flop
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= bus_d != BUS_ACK;
        end
    end

    // read data is captured on the edge that leaves idle and stands through the ack cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            readdata_q <= 32'h0000_0000;
        end
        else if (bus_q == BUS_IDLE && avs_read_in)
        begin
            readdata_q <= rd_word;
        end
    end

    // reserved bits are masked off on write and read back as zero
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            led3_q <= prox_cfg_pkg::RST_LED3;
        end
        else if (wr_take && hit_led3)
        begin
            led3_q <= wbyte & prox_cfg_pkg::MASK_LED3;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prox_align_q <= prox_cfg_pkg::RST_PROX_ALIGN;
        end
        else if (wr_take && hit_palign)
        begin
            prox_align_q <= wbyte & prox_cfg_pkg::MASK_PROX_ALIGN;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            amb_align_q <= prox_cfg_pkg::RST_AMB_ALIGN;
        end
        else if (wr_take && hit_aalign)
        begin
            amb_align_q <= wbyte & prox_cfg_pkg::MASK_AMB_ALIGN;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            insel1_q <= prox_cfg_pkg::RST_INSEL1;
        end
        else if (wr_take && hit_insel1)
        begin
            insel1_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_q <= prox_cfg_pkg::RST_CTRL;
        end
        else if (wr_take && hit_ctrl)
        begin
            ctrl_q <= {7'h00, wbyte[prox_cfg_pkg::BIT_CTRL_MODE]};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            led_q <= 3'b000;
        end
        else
        begin
            led_q <= led_next;
        end
    end

    // the adc code trails the register by one cycle, so it is always settled
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            adc_in_q <= prox_cfg_pkg::RST_INSEL1;
        end
        else
        begin
            adc_in_q <= insel1_q;
        end
    end

    // a bad code is only reported, so raw experiments stay possible
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            insel_bad_q <= 8'h00;
        end
        else
        begin
            insel_bad_q <= {7'h00, !code_ok};
        end
    end

    // one pulse per conversion; the value holds so the host can read it back
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            report_q <= '0;
        end
        else
        begin
            report_q.valid   <= conv_in.valid;
            report_q.channel <= conv_in.channel;
            if (conv_in.valid)
            begin
                report_q.value <= aligned;
            end
        end
    end

    assign avs_readdata_out    = readdata_q;
    assign avs_waitrequest_out = wait_q;
    assign led_drive_out       = led_q;
    assign adc_input_out       = adc_in_q;
    assign report_out          = report_q;
endmodule

// ---- bench/prox_cfg_sva.sv ----
/* checker: led mask, result alignment, input select and bus wait.
 assumes it is bound to the top module and that writes are held until acked. */
`timescale 1ns/1ps
module prox_cfg_sva
(
    input wire logic                              sys_clk_in,
    input wire logic                              reset_n_in,
    input wire logic [prox_cfg_pkg::ADDR_W-1:0]   avs_address_in,
    input wire logic                              avs_write_in,
    input wire logic [31:0]                       avs_writedata_in,
    input wire logic [3:0]                        avs_byteenable_in,
    input wire logic                              avs_waitrequest_out,
    input wire logic                              slot_active_in,
    input wire prox_cfg_pkg::channel_t            slot_channel_in,
    input wire prox_cfg_pkg::conversion_t         conv_in,
    input wire logic [2:0]                        led_drive_out,
    input wire logic [7:0]                        adc_input_out,
    input wire prox_cfg_pkg::report_t             report_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [2:0]  led_q;
    logic [7:0]  pal_q, aal_q, ins_q;
    logic        mode_q;
    // shadow updates at the ack edge; the write data is held until then
    wire         wr_ack = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    wire [7:0]   idx = {4'h0, avs_address_in};
    wire [2:0]   ch = conv_in.channel;
    wire         lo_sel = (ch < 3'h3) ? pal_q[3'h4 + ch] : aal_q[(ch == 3'h3) ? 5 : 4];
    wire [15:0]  exp_v = lo_sel ? conv_in.raw[15:0] : conv_in.raw[16:1];
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            {led_q, pal_q, aal_q} <= {3'h4, 8'h00, 8'h00};
            {ins_q, mode_q} <= {8'h03, 1'b1};
        end
        else if (wr_ack)
            case (idx)
                prox_cfg_pkg::IDX_LED3:       led_q <= avs_writedata_in[2:0];
                prox_cfg_pkg::IDX_PROX_ALIGN: pal_q <= avs_writedata_in[7:0];
                prox_cfg_pkg::IDX_AMB_ALIGN:  aal_q <= avs_writedata_in[7:0];
                prox_cfg_pkg::IDX_INSEL1:     ins_q <= avs_writedata_in[7:0];
                prox_cfg_pkg::IDX_CTRL:       mode_q <= avs_writedata_in[0];
                default: ;
            endcase
    sequence s_slot3;
        slot_active_in && slot_channel_in == prox_cfg_pkg::CH_PROX3 && mode_q;
    endsequence
    sequence s_result;
        report_out.valid && report_out.value == $past(exp_v) && report_out.channel == $past(ch);
    endsequence
    a_led_third_mask: assert property (s_slot3 |=> led_drive_out == $past(led_q))
        else $error("led drive differs from third slot mask");
    a_raw_led_off: assert property (slot_active_in && !mode_q |=> led_drive_out == 3'h0)
        else $error("led driven in raw mode");
    a_prox_align: assert property (conv_in.valid && ch < 3'h3 |=> s_result)
        else $error("proximity result alignment wrong");
    a_vis_align: assert property (conv_in.valid && ch == 3'h3 |=> s_result)
        else $error("visible result alignment wrong");
    a_ir_align: assert property (conv_in.valid && ch == 3'h4 |=> s_result)
        else $error("infrared result alignment wrong");
    a_input_follow: assert property (!avs_write_in |-> adc_input_out == $past(ins_q))
        else $error("adc input differs from written select");
    a_wait_once: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_report_cause: assert property (!conv_in.valid |=> !report_out.valid)
        else $error("report without conversion");
endmodule

// ---- bench/host_model.sv ----
/* host side: avalon-mm master that configures the block.
 assumes the slave acks each request by one cycle of waitrequest low. */
`timescale 1ns/1ps
module host_model
(
    input  wire logic                           clk_in,
    input  wire logic                           waitrequest_in,
    output logic [prox_cfg_pkg::ADDR_W-1:0]     address_out,
    output logic                                read_out,
    output logic                                write_out,
    output logic [31:0]                         writedata_out,
    output logic [3:0]                          byteenable_out,
    output logic                                hang_out
);
    initial {address_out, read_out, write_out, writedata_out, byteenable_out, hang_out} = '0;
    // the three-driver part is modelled, so led2 and led3 bits may be set
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        {address_out, read_out, write_out} <= {a, !wr, wr};
        {writedata_out, byteenable_out} <= {d, be};
        repeat (50)
        begin
            @(posedge clk_in);
            if (waitrequest_in === 1'b0) break;
            n++;
        end
        if (n == 50) hang_out <= 1'b1;
        {read_out, write_out} <= 2'b00;
        // released data no longer shows the last value
        writedata_out <= ~d;
    endtask
    // raw readings only mean something once a reference conversion is subtracted
    function automatic logic [15:0] net_reading(input logic [15:0] v, input logic [15:0] r,
                                                input logic neg);
        return neg ? r - v : v - r;
    endfunction
endmodule

// ---- bench/prox_ambient_measure_config_tb.sv ----
/* top bench: slots, conversions and register traffic checked through a queue.
 assumes host_model drives the bus and the checker is bound below. */
`timescale 1ns/1ps
module prox_ambient_measure_config_tb;
    logic                       sys_clk_in = 1'b0, reset_n_in = 1'b0, slot_q = 1'b0;
    logic                       probe_q = 1'b0, rd, wr, wait_rq, hang;
    prox_cfg_pkg::channel_t     chan_q = prox_cfg_pkg::CH_PROX3;
    prox_cfg_pkg::conversion_t  conv_q = '0;
    prox_cfg_pkg::report_t      report;
    logic [3:0]                 addr, be;
    logic [31:0]                wdata, rdata, seed = 32'h0000_0056, exp_q[$];
    logic [2:0]                 led;
    logic [7:0]                 adc, pa, aa, codes [7] = '{8'h03, 8'h00, 8'h02, 8'h06, 8'h25, 8'h65, 8'h75};
    logic [16:0]                raw;
    logic [15:0]                last_v;
    int                         fails = 0, checks_done = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    prox_ambient_measure_config prox_ambient_measure_config_inst (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_rq), .slot_active_in(slot_q), .slot_channel_in(chan_q),
        .conv_in(conv_q), .led_drive_out(led), .adc_input_out(adc), .report_out(report));
    host_model host_model_inst (.clk_in(sys_clk_in), .waitrequest_in(wait_rq), .address_out(addr),
        .read_out(rd), .write_out(wr), .writedata_out(wdata), .byteenable_out(be), .hang_out(hang));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got);
        logic [31:0] e;
        checks_done++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
        if (e !== got)
        begin
            fails++;
            $display("mismatch at %0t expected %h got %h", $time, e, got);
        end
    endtask
    always @(posedge sys_clk_in)
    begin
        if (rd && wait_rq === 1'b0) cmp(rdata);
        if (report.valid === 1'b1) cmp({13'h0, report.channel, report.value});
        if (probe_q) cmp({21'h0, adc, led});
    end
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host_model_inst.xfer(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        host_model_inst.xfer(1'b1, a, d, 4'h1);
    endtask
    // slot starts, the design samples it, then outputs are compared
    task automatic probe(input prox_cfg_pkg::channel_t c, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk_in) {slot_q, chan_q} <= {1'b1, c};
        @(posedge sys_clk_in) probe_q <= 1'b1;
        @(posedge sys_clk_in) {probe_q, slot_q} <= 2'b00;
    endtask
    task automatic end_sim();
        $display("fails=%0d checks_done=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge hang)
    begin
        fails++;
        end_sim();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rd_chk(4'h3, 32'h4);
        rd_chk(4'h5, 32'h0);
        rd_chk(4'h7, 32'h3);
        rd_chk(4'hc, 32'h1);
        rd_chk(4'hf, 32'h0);
        wr_reg(4'h3, 32'h0000_00ff);
        host_model_inst.xfer(1'b1, 4'h3, 32'h0, 4'h2);
        rd_chk(4'h3, 32'h7);
        wr_reg(4'h6, 32'h0000_00ff);
        rd_chk(4'h6, 32'h30);
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(4'h3, m);
            probe(prox_cfg_pkg::CH_PROX3, {21'h0, 8'h03, m[2:0]});
        end
        wr_reg(4'hc, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr_reg(4'h7, codes[i]);
            probe(prox_cfg_pkg::CH_PROX3, {21'h0, codes[i], 3'h0});
        end
        rd_chk(4'he, 32'h0);
        wr_reg(4'hc, 32'h1);
        rd_chk(4'he, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            wr_reg(4'h7, codes[i]);
            probe(prox_cfg_pkg::CH_PROX3, {21'h0, codes[i], 3'h7});
        end
        for (int k = 0; k < 4; k++)
        begin
            pa = (k == 0) ? 8'h00 : (k == 1) ? 8'h70 : rnd() & 8'h70;
            aa = (k == 0) ? 8'h00 : (k == 1) ? 8'h30 : rnd() & 8'h30;
            wr_reg(4'h5, pa);
            wr_reg(4'h6, aa);
            // back-to-back conversions over all five channels
            for (int c = 0; c < 5; c++)
            begin
                raw = rnd();
                exp_q.push_back({13'h0, 3'(c), ((c < 3) ? pa[4 + c] : aa[(c == 3) ? 5 : 4])
                                 ? raw[15:0] : raw[16:1]});
                last_v = exp_q[$][15:0];
                @(posedge sys_clk_in) conv_q <= {1'b1, 3'(c), raw};
            end
            @(posedge sys_clk_in) conv_q.valid <= 1'b0;
        end
        // let the last report be compared before anything else is queued
        repeat (2) @(posedge sys_clk_in);
        exp_q.push_back(32'h0020_0100);
        cmp({host_model_inst.net_reading(16'h0010, 16'h0030, 1'b1),
             host_model_inst.net_reading(16'h0125, 16'h0025, 1'b0)});
        rd_chk(4'hd, {16'h0000, last_v});
        reset_n_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rd_chk(4'h3, 32'h4);
        repeat (5) @(posedge sys_clk_in);
        if (exp_q.size() != 0) fails++;
        end_sim();
    end
endmodule
bind prox_ambient_measure_config prox_cfg_sva prox_cfg_sva_inst (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out), .slot_active_in(slot_active_in),
    .slot_channel_in(slot_channel_in), .conv_in(conv_in), .led_drive_out(led_drive_out),
    .adc_input_out(adc_input_out), .report_out(report_out));
